// file: lps_pkg.sv
package lps_pkg;
  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [7:0] CMD_NOP           = 8'h25;
  localparam logic [7:0] CMD_DISP_CTRL     = 8'hca;
  localparam logic [7:0] CMD_COM_SCAN      = 8'hbb;
  localparam logic [7:0] CMD_OSC_ON        = 8'hd1;
  localparam logic [7:0] CMD_OSC_OFF       = 8'hd2;
  localparam logic [7:0] CMD_SLEEP_EXIT    = 8'h94;
  localparam logic [7:0] CMD_SLEEP_ENTRY   = 8'h95;
  localparam logic [7:0] CMD_VOLUME        = 8'h81;
  localparam logic [7:0] CMD_SUPPLY        = 8'h20;
  localparam logic [7:0] CMD_DISP_NORMAL   = 8'ha6;
  localparam logic [7:0] CMD_DISP_INVERT   = 8'ha7;
  localparam logic [7:0] CMD_PARTIAL_ENTER = 8'ha8;
  localparam logic [7:0] CMD_PARTIAL_EXIT  = 8'ha9;
  localparam logic [7:0] CMD_DATA_LAYOUT   = 8'hbc;
  localparam logic [7:0] CMD_PALETTE       = 8'hce;
  localparam logic [7:0] CMD_PAGE_WIN      = 8'h75;
  localparam logic [7:0] CMD_COL_WIN       = 8'h15;
  localparam logic [7:0] CMD_MEM_WRITE     = 8'h5c;
  localparam logic [7:0] CMD_DISP_ON       = 8'haf;
  localparam logic [7:0] CMD_DISP_OFF      = 8'hae;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_DISP_CTRL0 = 8'h00;
  localparam logic [7:0] RST_DISP_CTRL1 = 8'h00;
  localparam logic [7:0] RST_DISP_CTRL2 = 8'h11;
  localparam logic [7:0] RST_COM_SCAN   = 8'h00;
  localparam logic [7:0] RST_VOL_ALPHA  = 8'h00;
  localparam logic [7:0] RST_VOL_RATIO  = 8'h00;
  localparam logic [7:0] RST_DATA_LAY0  = 8'h00;
  localparam logic [7:0] RST_DATA_LAY1  = 8'h00;
  localparam logic [7:0] RST_DATA_LAY2  = 8'h02;
  localparam logic [7:0] RST_PALETTE    = 8'h00;
  localparam logic [7:0] RST_WINDOW     = 8'h00;
  localparam int         PALETTE_DEPTH  = 20;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_HZ          = 25_000_000;
  localparam int SETTLE_MS       = 100;
  localparam int SETTLE_CYCLES   = SETTLE_MS * (CLK_HZ / 1000);
  localparam int RESET_HOLD_NS   = 350;
  localparam int RESET_HOLD_CYC  = (RESET_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================
  // APB register map of the host sequencer
  // ==========================================================
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WAIT   = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam int CTRL_POWER_UP   = 0;
  localparam int CTRL_POWER_DOWN = 1;
  localparam int CTRL_USE_RESET  = 2;
  localparam int CTRL_SLEEP      = 3;
  localparam int CTRL_WAKE       = 4;
  localparam int CTRL_PIXEL      = 5;
endpackage

// file: lps_link_if.sv
`timescale 1ns/100ps
interface lps_link_if;
  logic       resetN;
  logic       wrStrobe;
  logic       isData;
  logic [7:0] dataByte;
  logic       ready;
  modport host (output resetN, output wrStrobe, output isData, output dataByte, input ready);
  modport dev  (input resetN, input wrStrobe, input isData, input dataByte, output ready);
endinterface

// file: lps_wait_timer.sv
`timescale 1ns/100ps
module lps_wait_timer #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= count;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q <= 1) run_q <= 1'b0;
      cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
    end
  end

  assign done = run_q && (cnt_q <= 1);
endmodule // lps_wait_timer

// file: lps_device.sv
`timescale 1ns/100ps
// Behaviour
// - Host pulses reset low before setup
// - Host keeps inputs defined after reset
// - Display control defaults: divide 2, 1/4, 11h
// - Common scan defaults to forward order
// - Volume resistance ratio resets to zero
// - Reset: oscillator off, sleep, supplies off
// - Data layout defaults: normal, column, RGB, 8-level
// - Palette entries all reset to zero
// - RAM window addresses reset to zero
// - Memory write continues until another command
// - Host waits 100ms after supply command
// - Sleep exit before enabling supply
// - Host may skip default-valued setup
// - Non-reset power down command order
// - Display off blanks, outputs at centre
// - Oscillator off stops all internal circuits; the model only clears oscRunning
// - Reset-based power down: reset first
// - Avoid memory writes while sleeping
// - Sleep entry minimises power
// - Sleep keeps settings, RAM, accepts commands
// - Wake: exit, oscillator, wait, display on
// - Display on shows RAM contents
module lps_device
  import lps_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic       clk_sys,
  lps_link_if.dev         link,
  output logic            oscRunning,
  output logic            sleeping,
  output logic [2:0]      supplyOn,
  output logic            displayOn,
  output logic            centreDrive,
  output logic            inverted,
  output logic            partialOn,
  output logic [7:0]      dispCtrl [3],
  output logic [7:0]      comScan,
  output logic [7:0]      volAlpha,
  output logic [7:0]      volRatio,
  output logic [7:0]      dataLayout [3],
  output logic [7:0]      pageStart,
  output logic [7:0]      pageEnd,
  output logic [7:0]      colStart,
  output logic [7:0]      colEnd,
  output logic            pixelWrite,
  output logic [7:0]      pixelData,
  output logic [15:0]     pixelCount
);
  // ==========================================================
  // Command decode
  // ==========================================================
  logic       rst;
  logic       cmdStb;
  logic       datStb;
  logic [7:0] cmd_q;
  logic [4:0] argIdx_q;
  logic [7:0] palette_q [PALETTE_DEPTH];

  assign rst    = ~link.resetN;
  assign cmdStb = link.wrStrobe && !link.isData;
  assign datStb = link.wrStrobe && link.isData;
  assign link.ready = 1'b1;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_q    <= CMD_NOP;
      argIdx_q <= '0;
    end else if (cmdStb) begin
      cmd_q    <= link.dataByte;
      argIdx_q <= '0;
    end else if (datStb && argIdx_q != 5'h1f) begin
      argIdx_q <= argIdx_q + 5'h01;
    end
  end

  // ==========================================================
  // Power and display state
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oscRunning <= 1'b0;
      sleeping   <= 1'b1;
      supplyOn   <= 3'h0;
      displayOn  <= 1'b0;
      inverted   <= 1'b0;
      partialOn  <= 1'b0;
    end else if (cmdStb) begin
      unique case (link.dataByte)
        CMD_DISP_OFF:      displayOn  <= 1'b0;
        CMD_DISP_ON:       displayOn  <= 1'b1;
        CMD_OSC_ON:        oscRunning <= 1'b1;
        CMD_OSC_OFF:       oscRunning <= 1'b0;
        CMD_SLEEP_ENTRY: begin
          sleeping  <= 1'b1;
          displayOn <= 1'b0;
          supplyOn  <= 3'h0;
          oscRunning <= 1'b0;
        end
        CMD_SLEEP_EXIT:    sleeping   <= 1'b0;
        CMD_DISP_NORMAL:   inverted   <= 1'b0;
        CMD_DISP_INVERT:   inverted   <= 1'b1;
        CMD_PARTIAL_ENTER: partialOn  <= 1'b1;
        CMD_PARTIAL_EXIT:  partialOn  <= 1'b0;
        default: ;
      endcase
    end else if (datStb && cmd_q == CMD_SUPPLY && argIdx_q == 5'h00) begin
      supplyOn <= sleeping ? 3'h0 : link.dataByte[2:0];
    end
  end

  assign centreDrive = !displayOn;

  // ==========================================================
  // Settings held through sleep
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dispCtrl[0]   <= RST_DISP_CTRL0;
      dispCtrl[1]   <= RST_DISP_CTRL1;
      dispCtrl[2]   <= RST_DISP_CTRL2;
      comScan       <= RST_COM_SCAN;
      volAlpha      <= RST_VOL_ALPHA;
      volRatio      <= RST_VOL_RATIO;
      dataLayout[0] <= RST_DATA_LAY0;
      dataLayout[1] <= RST_DATA_LAY1;
      dataLayout[2] <= RST_DATA_LAY2;
      pageStart     <= RST_WINDOW;
      pageEnd       <= RST_WINDOW;
      colStart      <= RST_WINDOW;
      colEnd        <= RST_WINDOW;
    end else if (datStb) begin
      unique case (cmd_q)
        CMD_DISP_CTRL:
          if (argIdx_q < 5'h03) dispCtrl[argIdx_q[1:0]] <= link.dataByte;
        CMD_COM_SCAN:  if (argIdx_q == 5'h00) comScan <= link.dataByte;
        CMD_VOLUME: begin
          if (argIdx_q == 5'h00) volAlpha <= link.dataByte;
          if (argIdx_q == 5'h01) volRatio <= link.dataByte;
        end
        CMD_DATA_LAYOUT:
          if (argIdx_q < 5'h03) dataLayout[argIdx_q[1:0]] <= link.dataByte;
        CMD_PAGE_WIN: begin
          if (argIdx_q == 5'h00) pageStart <= link.dataByte;
          if (argIdx_q == 5'h01) pageEnd   <= link.dataByte;
        end
        CMD_COL_WIN: begin
          if (argIdx_q == 5'h00) colStart <= link.dataByte;
          if (argIdx_q == 5'h01) colEnd   <= link.dataByte;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < PALETTE_DEPTH; i++) begin
      if (rst) begin
        palette_q[i] <= RST_PALETTE;
      end else if (datStb && cmd_q == CMD_PALETTE && argIdx_q == 5'(i)) begin
        palette_q[i] <= link.dataByte;
      end
    end
  end

  // ==========================================================
  // Memory write stream
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pixelWrite <= 1'b0;
      pixelData  <= 8'h00;
      pixelCount <= 16'h0000;
    end else begin
      pixelWrite <= datStb && cmd_q == CMD_MEM_WRITE;
      if (datStb && cmd_q == CMD_MEM_WRITE) begin
        pixelData  <= link.dataByte;
        pixelCount <= pixelCount + 16'h0001;
      end else if (cmdStb && link.dataByte == CMD_MEM_WRITE) begin
        pixelCount <= 16'h0000;
      end
    end
  end
endmodule // lps_device

// file: lps_host.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module lps_host
  import lps_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  lps_link_if.host         link
);
  typedef enum {IDLE, RST_LOW, SEND, WAITING} lps_state_t;
  typedef enum {NONE, UP, DOWN, DOWN_RST, SLEEP, WAKE} lps_seq_t;

  lps_state_t  state_q;
  lps_seq_t    seq_q;
  logic [3:0]  step_q;
  logic [31:0] wait_q;
  logic [7:0]  pix_q;
  logic        pixPend_q;
  logic        sendPix_q;
  logic        rstN_q;
  logic [8:0]  item;
  logic        lastStep;
  logic        timerStart;
  logic        timerDone;
  logic        busy;
  logic [15:0] rstCnt_q;
  logic        apbWr;

  assign busy    = state_q != IDLE;
  assign pready  = 1'b1;
  assign apbWr   = psel && penable && pwrite;
  assign pslverr = psel && penable && paddr > REG_WDATA;

  // ==========================================================
  // Command scripts: {isData, byte}; 9'h0ff waits, 9'h1ff ends
  // ==========================================================
  always_comb begin
    item = 9'h1ff;
    unique case (seq_q)
      UP: unique case (step_q)
        4'd0: item = {1'b0, CMD_SLEEP_EXIT};
        4'd1: item = {1'b0, CMD_OSC_ON};
        4'd2: item = {1'b0, CMD_SUPPLY};
        4'd3: item = {1'b1, 8'h0f};
        4'd4: item = 9'h0ff;
        4'd5: item = {1'b0, CMD_DISP_ON};
        default: item = 9'h1ff;
      endcase
      DOWN: unique case (step_q)
        4'd0: item = {1'b0, CMD_DISP_OFF};
        4'd1: item = {1'b0, CMD_SUPPLY};
        4'd2: item = {1'b1, 8'h00};
        4'd3: item = {1'b0, CMD_OSC_OFF};
        4'd4: item = {1'b0, CMD_SLEEP_ENTRY};
        default: item = 9'h1ff;
      endcase
      SLEEP: unique case (step_q)
        4'd0: item = {1'b0, CMD_DISP_OFF};
        4'd1: item = {1'b0, CMD_SUPPLY};
        4'd2: item = {1'b1, 8'h00};
        4'd3: item = {1'b0, CMD_OSC_OFF};
        4'd4: item = {1'b0, CMD_SLEEP_ENTRY};
        default: item = 9'h1ff;
      endcase
      WAKE: unique case (step_q)
        4'd0: item = {1'b0, CMD_SLEEP_EXIT};
        4'd1: item = {1'b0, CMD_OSC_ON};
        4'd2: item = 9'h0ff;
        4'd3: item = {1'b0, CMD_DISP_ON};
        default: item = 9'h1ff;
      endcase
      default: item = 9'h1ff;
    endcase
  end

  assign lastStep   = item == 9'h1ff;
  assign timerStart = state_q == SEND && !sendPix_q && item == 9'h0ff;

  lps_wait_timer #(.W(32)) lps_wait_timer_inst (
    .clk_sys (clk_sys),
    .srst    (srst),
    .start   (timerStart),
    .count   (wait_q),
    .done    (timerDone)
  );

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wait_q    <= 32'(SETTLE_CYCLES);
      pix_q     <= 8'h00;
      pixPend_q <= 1'b0;
    end else begin
      if (apbWr && paddr == REG_WAIT) wait_q <= pwdata;
      if (apbWr && paddr == REG_WDATA) begin
        pix_q     <= pwdata[7:0];
        pixPend_q <= 1'b1;
      end else if (sendPix_q) begin
        pixPend_q <= 1'b0;
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (paddr)
        REG_STATUS: prdata = {26'h0, pixPend_q, !rstN_q, 1'(seq_q == WAKE || seq_q == UP),
                              1'(state_q == WAITING), 1'(state_q == RST_LOW), busy};
        REG_WAIT:   prdata = wait_q;
        REG_WDATA:  prdata = {24'h0, pix_q};
        default:    prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q       <= IDLE;
      seq_q         <= NONE;
      step_q        <= 4'h0;
      rstN_q        <= 1'b1;
      rstCnt_q      <= 16'h0;
      sendPix_q     <= 1'b0;
      link.wrStrobe <= 1'b0;
      link.isData   <= 1'b0;
      link.dataByte <= 8'h00;
    end else begin
      link.wrStrobe <= 1'b0;
      sendPix_q     <= 1'b0;
      unique case (state_q)
        IDLE: begin
          step_q <= 4'h0;
          if (apbWr && paddr == REG_CTRL) begin
            if (pwdata[CTRL_POWER_UP]) begin
              seq_q <= UP;
              rstN_q <= 1'b0;
              rstCnt_q <= 16'(RESET_HOLD_CYC);
              state_q <= RST_LOW;
            end else if (pwdata[CTRL_POWER_DOWN] && pwdata[CTRL_USE_RESET]) begin
              seq_q <= DOWN_RST;
              rstN_q <= 1'b0;
              state_q <= IDLE;
            end else if (pwdata[CTRL_POWER_DOWN]) begin
              seq_q <= DOWN;
              state_q <= SEND;
            end else if (pwdata[CTRL_SLEEP]) begin
              seq_q <= SLEEP;
              state_q <= SEND;
            end else if (pwdata[CTRL_WAKE]) begin
              seq_q <= WAKE;
              state_q <= SEND;
            end else if (pwdata[CTRL_PIXEL]) begin
              link.wrStrobe <= 1'b1;
              link.isData   <= 1'b0;
              link.dataByte <= CMD_MEM_WRITE;
            end
          end else if (pixPend_q && !sendPix_q
                       && (seq_q == UP || seq_q == WAKE)) begin
            link.wrStrobe <= 1'b1;
            link.isData   <= 1'b1;
            link.dataByte <= pix_q;
            sendPix_q     <= 1'b1;
          end
        end
        RST_LOW: begin
          if (rstCnt_q <= 16'h1) begin
            rstN_q  <= 1'b1;
            state_q <= SEND;
          end
          rstCnt_q <= rstCnt_q - 16'h1;
        end
        SEND: begin
          if (lastStep) begin
            state_q <= IDLE;
          end else if (item == 9'h0ff) begin
            state_q <= WAITING;
          end else if (link.ready) begin
            link.wrStrobe <= 1'b1;
            link.isData   <= item[8];
            link.dataByte <= item[7:0];
            step_q        <= step_q + 4'h1;
          end
        end
        WAITING: if (timerDone) begin
          step_q  <= step_q + 4'h1;
          state_q <= SEND;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  assign link.resetN = rstN_q;
endmodule // lps_host

// file: lps_props.sv
`timescale 1ns/100ps
module lps_props
  import lps_pkg::*;
#(
  parameter int WAIT_MIN = 20
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       resetN,
  input wire logic       wrStrobe,
  input wire logic       isData,
  input wire logic [7:0] dataByte,
  input wire logic       ready
);
  // ==========================================================
  // Helper state
  // ==========================================================
  logic        cmdStb;
  logic [7:0]  lastCmd_q;
  logic        awake_q;
  logic [31:0] sinceKick_q;

  assign cmdStb = wrStrobe && !isData;

  always_ff @(posedge clk_sys) begin
    if (srst) lastCmd_q <= 8'h00;
    else if (cmdStb) lastCmd_q <= dataByte;
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !resetN) awake_q <= 1'b0;
    else if (cmdStb && dataByte == CMD_SLEEP_EXIT) awake_q <= 1'b1;
    else if (cmdStb && dataByte == CMD_SLEEP_ENTRY) awake_q <= 1'b0;
  end

  // Cycles since the last oscillator-on or supply command
  always_ff @(posedge clk_sys) begin
    if (srst) sinceKick_q <= 32'h0;
    else if (cmdStb && (dataByte == CMD_OSC_ON || dataByte == CMD_SUPPLY)) sinceKick_q <= 32'h0;
    else if (sinceKick_q != 32'hffff_ffff) sinceKick_q <= sinceKick_q + 32'h1;
  end

  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  chk_reset_quiet: assert property (disable iff (1'b0) $fell(srst) |-> resetN && !wrStrobe)
    else $error("link not idle after reset");
  chk_ready_high: assert property (ready)
    else $error("device not ready");
  chk_reset_hold: assert property ($fell(resetN) |-> (!resetN) [*8])
    else $error("reset pulse too short");
  chk_reset_silent: assert property (!resetN |-> !wrStrobe)
    else $error("strobe during device reset");
  chk_osc_after_exit: assert property (cmdStb && dataByte == CMD_OSC_ON
    |-> lastCmd_q == CMD_SLEEP_EXIT)
    else $error("oscillator on without sleep exit");
  chk_supply_awake: assert property (wrStrobe && isData && lastCmd_q == CMD_SUPPLY
    && dataByte != 8'h00 |-> awake_q)
    else $error("supply enabled while asleep");
  chk_disp_on_wait: assert property (cmdStb && dataByte == CMD_DISP_ON
    |-> sinceKick_q >= WAIT_MIN)
    else $error("display on too early");
  chk_osc_off_order: assert property (cmdStb && dataByte == CMD_OSC_OFF
    |-> lastCmd_q == CMD_SUPPLY)
    else $error("oscillator off out of order");
  chk_sleep_order: assert property (cmdStb && dataByte == CMD_SLEEP_ENTRY
    |-> lastCmd_q == CMD_OSC_OFF)
    else $error("sleep entry out of order");
  chk_pixel_awake: assert property (wrStrobe && isData && lastCmd_q == CMD_MEM_WRITE
    |-> awake_q)
    else $error("memory write while asleep");
endmodule // lps_props

// file: tb_lcd_driver_power_sleep_sequencing.sv
`timescale 1ns/100ps
module tb_lcd_driver_power_sleep_sequencing;
  import lps_pkg::*;
  localparam int WAIT_CYC = 20;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, lastErr;
  logic        oscRunning, sleeping, displayOn, centreDrive, inverted, partialOn, pixelWrite;
  logic [2:0]  supplyOn;
  logic [7:0]  dispCtrl [3];
  logic [7:0]  dataLayout [3];
  logic [7:0]  comScan, volAlpha, volRatio, pageStart, pageEnd, colStart, colEnd, pixelData;
  logic [15:0] pixelCount;
  int          miscompares = 0;
  int          n_checks = 0;
  int          pulses = 0;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pixelWrite === 1'b1) pulses++;

  lps_link_if lps_link_if_inst ();
  lps_host lps_host_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lps_link_if_inst));
  lps_device #(.ADDR_W(8)) lps_device_inst (.clk_sys(clk_sys), .link(lps_link_if_inst),
    .oscRunning(oscRunning), .sleeping(sleeping), .supplyOn(supplyOn), .displayOn(displayOn),
    .centreDrive(centreDrive), .inverted(inverted), .partialOn(partialOn),
    .dispCtrl(dispCtrl), .comScan(comScan), .volAlpha(volAlpha), .volRatio(volRatio),
    .dataLayout(dataLayout), .pageStart(pageStart), .pageEnd(pageEnd), .colStart(colStart),
    .colEnd(colEnd), .pixelWrite(pixelWrite), .pixelData(pixelData), .pixelCount(pixelCount));
  lps_props #(.WAIT_MIN(WAIT_CYC)) lps_props_inst (.clk_sys(clk_sys), .srst(srst),
    .resetN(lps_link_if_inst.resetN), .wrStrobe(lps_link_if_inst.wrStrobe),
    .isData(lps_link_if_inst.isData), .dataByte(lps_link_if_inst.dataByte),
    .ready(lps_link_if_inst.ready));

  // ==========================================================
  // Reporting and comparison
  // ==========================================================
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    miscompares++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) fail(msg);
  endtask

  // Sleep, oscillator, supply, display, inversion, partial
  function automatic logic [7:0] st();
    return {sleeping, oscRunning, supplyOn, displayOn, inverted, partialOn};
  endfunction

  // ==========================================================
  // APB master
  // ==========================================================
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd      = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_write(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    apb_xfer(1'b1, a, wd, rd);
  endtask

  task automatic wait_idle();
    logic [31:0] rd;
    int          n;
    n = 0;
    do begin
      apb_xfer(1'b0, REG_STATUS, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (rd[0] !== 1'b0) fail("sequencer stuck busy");
    repeat (2) @(negedge clk_sys);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_regs();
    logic [31:0] rd;
    apb_write(REG_WAIT, WAIT_CYC);
    apb_xfer(1'b0, REG_WAIT, 32'h0, rd);
    chk_word(rd, WAIT_CYC, "wait count readback");
    apb_xfer(1'b0, 8'h10, 32'h0, rd);
    chk_bit(lastErr, 1'b1, "unmapped address accepted");
  endtask

  task automatic test_power_up();
    logic [31:0] rd;
    int          n;
    n = 0;
    apb_write(REG_CTRL, 32'h1);
    apb_xfer(1'b0, REG_STATUS, 32'h0, rd);
    chk_bit(rd[0], 1'b1, "not busy in power-up");
    while (lps_link_if_inst.resetN !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk_bit(lps_link_if_inst.resetN, 1'b0, "no reset pulse");
    chk_byte(st(), 8'h80, "power state after reset");
    chk_word({dispCtrl[0], dispCtrl[1], dispCtrl[2], comScan}, 32'h0000_1100,
             "display defaults");
    chk_word({volRatio, dataLayout[0], dataLayout[1], dataLayout[2]}, 32'h0000_0002,
             "volume and layout defaults");
    chk_byte(volAlpha, RST_VOL_ALPHA, "volume alpha default");
    chk_word({pageStart, pageEnd, colStart, colEnd}, 32'h0, "window defaults");
    for (int i = 0; i < PALETTE_DEPTH; i++)
      chk_byte(lps_device_inst.palette_q[i], RST_PALETTE, "palette not cleared");
    chk_bit(centreDrive, 1'b1, "outputs not at centre");
    wait_idle();
    chk_byte(st() & 8'hc7, 8'h44, "state after power-up");
    chk_bit(|supplyOn, 1'b1, "supply not on");
    chk_bit(centreDrive, 1'b0, "outputs still at centre");
  endtask

  task automatic test_mem_write();
    int p0;
    p0 = pulses;
    apb_write(REG_CTRL, 32'h20);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      apb_write(REG_WDATA, 32'ha0 + i);
      wait_idle();
    end
    chk_word(pulses - p0, 32'd3, "pixel write count");
    chk_byte(pixelData, 8'ha2, "last pixel byte");
    chk_word({16'h0, pixelCount}, 32'd3, "pixel count");
  endtask

  task automatic test_sleep_wake();
    apb_write(REG_CTRL, 32'h8);
    wait_idle();
    chk_byte(st(), 8'h80, "state in sleep");
    chk_bit(centreDrive, 1'b1, "outputs not at centre in sleep");
    chk_word({dispCtrl[0], dispCtrl[1], dispCtrl[2], comScan}, 32'h0000_1100,
             "settings lost in sleep");
    chk_byte(pixelData, 8'ha2, "pixel data lost in sleep");
    apb_write(REG_WDATA, 32'h55);
    wait_idle();
    chk_word({16'h0, pixelCount}, 32'd3, "pixel sent while asleep");
    apb_write(REG_CTRL, 32'h10);
    wait_idle();
    chk_byte(st() & 8'hc7, 8'h44, "state after wake");
    chk_word({16'h0, pixelCount}, 32'd3, "pixel stream not ended");
  endtask

  task automatic test_power_down();
    apb_write(REG_CTRL, 32'h2);
    wait_idle();
    chk_byte(st(), 8'h80, "state after power-down");
    chk_bit(lps_link_if_inst.resetN, 1'b1, "reset used without request");
  endtask

  task automatic test_power_down_reset();
    apb_write(REG_CTRL, 32'h1);
    apb_write(REG_CTRL, 32'h2);
    wait_idle();
    chk_bit(displayOn, 1'b1, "busy request not refused");
    apb_write(REG_CTRL, 32'h6);
    wait_idle();
    repeat (3) @(negedge clk_sys);
    chk_bit(lps_link_if_inst.resetN, 1'b0, "reset not held");
    chk_byte(st(), 8'h80, "state with reset held");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    test_regs();
    test_power_up();
    test_mem_write();
    test_sleep_wake();
    test_power_down();
    test_power_down_reset();
    report_and_stop();
  end

  initial begin
    #(40 * 20000);
    fail("timeout");
    report_and_stop();
  end
endmodule // tb_lcd_driver_power_sleep_sequencing
